// [trig_timer_pkg.sv]
package trig_timer_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register word offsets
    localparam logic [3:0] OFS_RUN_CTL = 4'h0;
    localparam logic [3:0] OFS_MODE_CTL = 4'h1;
    localparam logic [3:0] OFS_PERIOD = 4'h2;
    localparam logic [3:0] OFS_CH1 = 4'h3;
    localparam logic [3:0] OFS_CH2 = 4'h4;
    localparam logic [3:0] OFS_CH3 = 4'h5;
    localparam logic [3:0] OFS_COUNT = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    // Field positions
    localparam int RUN_ENABLE_BIT = 7;
    localparam int SOFT_TRIGGER_BIT = 6;
    localparam int EVENT_SOURCE_BIT = 5;
    localparam int STAT_RUNNING_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    // Writable masks and reset values
    localparam logic [7:0] RUN_CTL_MASK = 8'h87;
    localparam logic [7:0] MODE_CTL_MASK = 8'h27;
    localparam logic [7:0] RUN_CTL_RST = 8'h00;
    localparam logic [7:0] MODE_CTL_RST = 8'h00;
    localparam logic [15:0] CCR_RST = 16'h0000;
    localparam logic [15:0] CNT_PARK = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // Mode field encodings
    localparam logic [2:0] MODE_TRIG_PWM = 3'h2;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
    // Default prescaler table: log2 of the divider for each select value
    localparam logic [31:0] DIV_LOG2_DEFAULT = 32'h7654_3210;
endpackage

// [count_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface count_tick_if;
    logic [2:0] prescale_sel;
    logic event_sel;
    logic event_in;
    logic tick;
    modport gen (input prescale_sel, input event_sel, input event_in, output tick);
    modport core (output prescale_sel, output event_sel, output event_in, input tick);
endinterface
`default_nettype wire

// [count_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen #(
    parameter int DIV_W = 16,
    parameter logic [31:0] DIV_LOG2 = trig_timer_pkg::DIV_LOG2_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    count_tick_if.gen cs
);
    // ****************************************
    // Parameter check
    // ****************************************
    for (genvar i = 0; i < 8; i++) begin : g_chk
        if (int'(DIV_LOG2[i*4 +: 4]) >= DIV_W) begin : g_bad
            $error("prescaler table entry exceeds divider width");
        end
    end

    logic [DIV_W-1:0] div_q;
    logic ev_prev_q;
    logic tick_q;

    wire [3:0] sel_log2 = DIV_LOG2[{cs.prescale_sel, 2'b00} +: 4];
    wire [DIV_W-1:0] div_mask = (DIV_W'(1) << sel_log2) - DIV_W'(1);
    wire pre_hit = (div_q & div_mask) == div_mask;
    wire ev_edge = cs.event_in & ~ev_prev_q;
    // External edges replace the prescaled clock when selected
    wire tick_d = cs.event_sel ? ev_edge : pre_hit;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_q <= '0;
            ev_prev_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_q + DIV_W'(1);
            ev_prev_q <= cs.event_in;
            tick_q <= tick_d;
        end
    end

    assign cs.tick = tick_q;
endmodule
`default_nettype wire

// [triggered_pulse_timer.sv]
// Behaviour
// - Only a write to compare register 1 arms the shadow buffer update.
// - Once armed, next counter clear copies all four compares into shadows.
// - Compare zero gives inactive output; period FFFFH still gives channel interrupts.
// - Compare equal to period plus one is always active; impossible at FFFFH.
// - Trigger just after channel match clears counter and reasserts the output.
// - Trigger just before channel match suppresses it; output stays active.
// - Trigger just after period match clears counter and keeps counting.
// - Trigger just before period match suppresses it and reasserts outputs.
// - Triggered channel interrupt comes in the cycle count equals the buffer.
// - Mode value 011 selects one-shot; with run enable it waits for trigger.
// - One-shot trigger clears counter FFFFH to 0000H and pulses outputs 1-3.
// - After the one-shot pulse the counter parks at FFFFH and waits.
// - One-shot triggers arriving during the pulse are ignored.
// - One-shot delay is channel value; width is period minus channel plus one.
// - One-shot period interrupt follows the match; channel interrupt on match.
// - Trigger is an external edge or writing 1 to the soft trigger bit.
// - With soft triggers in one-shot, output 0 is active while counting.
// - Event select picks prescaled clock or external event edges as count source.
// - Mode value 010 selects triggered PWM; a trigger clears and restarts.
// - PWM active width is channel value; period is period value plus one.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module triggered_pulse_timer #(
    parameter int DIV_W = 16,
    parameter logic [31:0] DIV_LOG2 = trig_timer_pkg::DIV_LOG2_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [trig_timer_pkg::ADDR_W-1:0] addr,
    input wire logic [trig_timer_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [trig_timer_pkg::DATA_W-1:0] rdata,
    input wire logic trig_in,
    input wire logic event_in,
    output logic pulse_out_1,
    output logic pulse_out_2,
    output logic pulse_out_3,
    output logic aux_toggle_out,
    output logic period_match_irq,
    output logic [2:0] channel_match_irq
);
    // ****************************************
    // Registers and storage
    // ****************************************
    logic [7:0] run_ctl_q;
    logic [7:0] mode_ctl_q;
    logic [15:0] ccr_q [4];
    logic [15:0] shadow_q [4];
    logic [15:0] cnt_q;
    logic running_q;
    logic armed_q;
    logic trig_prev_q;
    logic aux_q;
    logic per_irq_q;
    logic [2:0] ch_irq_q;
    logic [2:0] pulse_q;
    logic [15:0] rdata_q;

    count_tick_if cti ();

    count_tick_gen #(
        .DIV_W(DIV_W),
        .DIV_LOG2(DIV_LOG2)
    ) u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .cs(cti.gen)
    );

    assign cti.prescale_sel = run_ctl_q[2:0];
    assign cti.event_sel = mode_ctl_q[trig_timer_pkg::EVENT_SOURCE_BIT];
    assign cti.event_in = event_in;

    // ****************************************
    // Decoding
    // ****************************************
    wire tick = cti.tick;
    wire run_en = run_ctl_q[trig_timer_pkg::RUN_ENABLE_BIT];
    wire [2:0] mode = mode_ctl_q[2:0];
    wire mode_pwm = run_en && (mode == trig_timer_pkg::MODE_TRIG_PWM);
    wire mode_os = run_en && (mode == trig_timer_pkg::MODE_ONE_SHOT);
    wire wr_run = wr && (addr == trig_timer_pkg::OFS_RUN_CTL);
    wire wr_mode = wr && (addr == trig_timer_pkg::OFS_MODE_CTL);
    wire wr_ch1 = wr && (addr == trig_timer_pkg::OFS_CH1);
    wire trig_edge = trig_in & ~trig_prev_q;
    wire soft_trig = wr_mode && wdata[trig_timer_pkg::SOFT_TRIGGER_BIT];
    wire trig = trig_edge | soft_trig;

    // Triggered PWM compares against shadows, one-shot against live values
    logic [15:0] cmp [4];
    logic [15:0] nxt_cmp [4];
    logic [3:0] wr_ccr;

    // ****************************************
    // Counter sequencing
    // ****************************************
    logic [15:0] cnt_d;
    logic run_d;
    logic step;
    logic clr;
    logic per_irq_d;
    wire load = mode_pwm && clr && armed_q;

    always_comb begin
        cnt_d = cnt_q;
        run_d = running_q;
        step = 1'b0;
        clr = 1'b0;
        per_irq_d = 1'b0;
        if (!(mode_pwm || mode_os)) begin
            cnt_d = trig_timer_pkg::CNT_PARK;
            run_d = 1'b0;
        end else if (trig && (mode_pwm || !running_q)) begin
            // Trigger clear never raises the period or channel interrupts
            cnt_d = trig_timer_pkg::CNT_ZERO;
            run_d = 1'b1;
            clr = 1'b1;
        end else if (running_q && tick) begin
            step = 1'b1;
            if (cnt_q == cmp[0]) begin
                per_irq_d = 1'b1;
                if (mode_os) begin
                    cnt_d = trig_timer_pkg::CNT_PARK;
                    run_d = 1'b0;
                    step = 1'b0;
                end else begin
                    cnt_d = trig_timer_pkg::CNT_ZERO;
                    clr = 1'b1;
                end
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // Per channel compare and outputs
    // ****************************************
    logic [2:0] pulse_d;
    logic [2:0] ch_irq_d;

    for (genvar m = 0; m < 4; m++) begin : g_cmp
        assign wr_ccr[m] = wr && (addr == trig_timer_pkg::OFS_PERIOD + 4'(m));
        assign cmp[m] = mode_pwm ? shadow_q[m] : ccr_q[m];
        assign nxt_cmp[m] = load ? ccr_q[m] : cmp[m];
    end

    for (genvar k = 0; k < 3; k++) begin : g_ch
        // PWM: active below the compare; one-shot: active from compare onward
        assign pulse_d[k] = run_d && (mode_pwm ? (cnt_d < nxt_cmp[k+1])
                                               : (cnt_d >= nxt_cmp[k+1]));
        assign ch_irq_d[k] = step && (cnt_d == nxt_cmp[k+1]);
    end

    wire aux_d = mode_os ? run_d : (mode_pwm ? (aux_q ^ clr) : 1'b0);

    // ****************************************
    // Register read mux
    // ****************************************
    logic [15:0] rd_mux;
    always_comb begin
        case (addr)
            trig_timer_pkg::OFS_RUN_CTL: rd_mux = {8'h00, run_ctl_q};
            trig_timer_pkg::OFS_MODE_CTL: rd_mux = {8'h00, mode_ctl_q};
            trig_timer_pkg::OFS_PERIOD: rd_mux = ccr_q[0];
            trig_timer_pkg::OFS_CH1: rd_mux = ccr_q[1];
            trig_timer_pkg::OFS_CH2: rd_mux = ccr_q[2];
            trig_timer_pkg::OFS_CH3: rd_mux = ccr_q[3];
            trig_timer_pkg::OFS_COUNT: rd_mux = cnt_q;
            trig_timer_pkg::OFS_STATUS: rd_mux = {14'h0000, armed_q, running_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    // ****************************************
    // Flip-flops
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run_ctl_q <= trig_timer_pkg::RUN_CTL_RST;
            mode_ctl_q <= trig_timer_pkg::MODE_CTL_RST;
        end else begin
            if (wr_run) begin
                run_ctl_q <= wdata[7:0] & trig_timer_pkg::RUN_CTL_MASK;
            end
            if (wr_mode) begin
                mode_ctl_q <= wdata[7:0] & trig_timer_pkg::MODE_CTL_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int m = 0; m < 4; m++) begin
            if (!reset_n) begin
                ccr_q[m] <= trig_timer_pkg::CCR_RST;
                shadow_q[m] <= trig_timer_pkg::CCR_RST;
            end else begin
                if (wr_ccr[m]) begin
                    ccr_q[m] <= wdata;
                end
                if (load) begin
                    shadow_q[m] <= ccr_q[m];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
        end else if (wr_ch1) begin
            armed_q <= 1'b1;
        end else if (load) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= trig_timer_pkg::CNT_PARK;
            running_q <= 1'b0;
            trig_prev_q <= 1'b0;
            aux_q <= 1'b0;
            per_irq_q <= 1'b0;
            ch_irq_q <= 3'h0;
            pulse_q <= 3'h0;
            rdata_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
            running_q <= run_d;
            trig_prev_q <= trig_in;
            aux_q <= aux_d;
            per_irq_q <= per_irq_d;
            ch_irq_q <= ch_irq_d;
            pulse_q <= pulse_d;
            rdata_q <= rd ? rd_mux : 16'h0000;
        end
    end

    assign rdata = rdata_q;
    assign pulse_out_1 = pulse_q[0];
    assign pulse_out_2 = pulse_q[1];
    assign pulse_out_3 = pulse_q[2];
    assign aux_toggle_out = aux_q;
    assign period_match_irq = per_irq_q;
    assign channel_match_irq = ch_irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_os_start;
        mode_os && !running_q && trig;
    endsequence

    sequence s_os_end;
        mode_os && running_q && tick && !trig && (cnt_q == cmp[0]);
    endsequence

    sequence s_pwm_wrap;
        mode_pwm && running_q && tick && !trig && (cnt_q == cmp[0]);
    endsequence

    property p_arm_only_ch1;
        $rose(armed_q) |-> $past(wr_ch1);
    endproperty
    a_arm_only_ch1: assert property (p_arm_only_ch1) else $error("arm without ch1 write");

    property p_shadow_load;
        (mode_pwm && clr && armed_q) |=> (shadow_q[0] == $past(ccr_q[0])) &&
            (shadow_q[3] == $past(ccr_q[3])) && !armed_q || $past(wr_ch1);
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

    property p_zero_inactive;
        (mode_pwm && $past(mode_pwm) && cmp[1] == 16'h0000) |-> !pulse_out_1;
    endproperty
    a_zero_inactive: assert property (p_zero_inactive) else $error("zero compare active");

    property p_full_on;
        (mode_pwm && $past(mode_pwm) && running_q && {1'b0, cmp[1]} == {1'b0, cmp[0]} + 17'h00001)
            |-> pulse_out_1;
    endproperty
    a_full_on: assert property (p_full_on) else $error("full compare inactive");

    property p_trig_clear;
        (mode_pwm && trig) |=> (cnt_q == 16'h0000) && running_q && !period_match_irq
            && (channel_match_irq == 3'h0);
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger did not clear");

    property p_ch_irq_same;
        (mode_pwm && $past(mode_pwm) && channel_match_irq[0]) |-> (cnt_q == cmp[1]);
    endproperty
    a_ch_irq_same: assert property (p_ch_irq_same) else $error("channel irq off match");

    property p_os_start;
        s_os_start |=> running_q && (cnt_q == 16'h0000) && aux_toggle_out;
    endproperty
    a_os_start: assert property (p_os_start) else $error("one-shot did not start");

    property p_os_park;
        s_os_end |=> (cnt_q == 16'hffff) && !running_q && period_match_irq && !aux_toggle_out;
    endproperty
    a_os_park: assert property (p_os_park) else $error("one-shot did not park");

    property p_os_ignore;
        (mode_os && running_q && trig && !tick) |=> $stable(cnt_q) && running_q;
    endproperty
    a_os_ignore: assert property (p_os_ignore) else $error("trigger not ignored");

    property p_aux_running;
        (mode_os && $past(mode_os)) |-> (aux_toggle_out == running_q);
    endproperty
    a_aux_running: assert property (p_aux_running) else $error("aux not tracking run");

    property p_stop;
        !run_en |=> (cnt_q == 16'hffff) && !running_q && !pulse_out_1 && !pulse_out_3;
    endproperty
    a_stop: assert property (p_stop) else $error("counter not stopped");

    property p_os_wait;
        (mode_os && !running_q && !trig) |=> (cnt_q == 16'hffff) && !running_q
            && !aux_toggle_out;
    endproperty
    a_os_wait: assert property (p_os_wait) else $error("one-shot not waiting");

    property p_pwm_wrap;
        s_pwm_wrap |=> (cnt_q == 16'h0000) && period_match_irq && running_q;
    endproperty
    a_pwm_wrap: assert property (p_pwm_wrap) else $error("period wrap wrong");

    property p_trig_out;
        (mode_pwm && trig) |=> !mode_pwm || (pulse_out_1 == (cmp[1] != 16'h0000));
    endproperty
    a_trig_out: assert property (p_trig_out) else $error("no reassert");
endmodule
`default_nettype wire

// [far_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Trigger source and pulse output loads
// ****************************************
module far_side_model (
    input wire logic clk,
    input wire logic [2:0] pulse_out,
    input wire logic aux,
    input wire logic prd_irq,
    input wire logic [2:0] ch_irq,
    output logic trig_in
);
    int cyc;
    int n_prd;
    int n_aux;
    int aux_rise;
    int aux_fall;
    int hi[3];
    int n_ch[3];
    int rise[3];
    int fall[3];
    logic [2:0] po_q;
    logic aux_q;

    initial begin
        trig_in = 1'b0;
        cyc = 0;
        po_q = 3'h0;
        aux_q = 1'b0;
        clear();
    end

    // Loads sample the settled outputs and stamp every edge
    always @(negedge clk) begin
        for (int k = 0; k < 3; k++) begin
            hi[k] += int'(pulse_out[k] === 1'b1);
            n_ch[k] += int'(ch_irq[k] === 1'b1);
            if (pulse_out[k] === 1'b1 && po_q[k] === 1'b0) rise[k] = cyc;
            if (pulse_out[k] === 1'b0 && po_q[k] === 1'b1) fall[k] = cyc;
        end
        n_prd += int'(prd_irq === 1'b1);
        if (aux === 1'b1 && aux_q === 1'b0) begin
            n_aux++;
            aux_rise = cyc;
        end
        if (aux === 1'b0 && aux_q === 1'b1) aux_fall = cyc;
        po_q = pulse_out;
        aux_q = aux;
        cyc++;
    end

    // Rising edge on the trigger line, held for two samples
    task automatic fire(output int t);
        @(posedge clk);
        trig_in <= 1'b1;
        t = cyc;
        repeat (2) @(posedge clk);
        trig_in <= 1'b0;
    endtask

    task automatic clear();
        n_prd = 0;
        n_aux = 0;
        for (int k = 0; k < 3; k++) begin
            hi[k] = 0;
            n_ch[k] = 0;
        end
    endtask
endmodule
`default_nettype wire

// [triggered_pulse_timer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module triggered_pulse_timer_tb_top;
    logic clk;
    logic reset_n;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic trig_in;
    logic event_in;
    logic [2:0] po;
    logic aux;
    logic prd_irq;
    logic [2:0] ch_irq;
    int num_errors;
    int n_checks;
    int seed;
    int p;
    int ck;
    int w2;
    int t;
    int c[3];

    triggered_pulse_timer dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in), .event_in(event_in),
        .pulse_out_1(po[0]), .pulse_out_2(po[1]), .pulse_out_3(po[2]),
        .aux_toggle_out(aux), .period_match_irq(prd_irq), .channel_match_irq(ch_irq));

    far_side_model far_u (.clk(clk), .pulse_out(po), .aux(aux), .prd_irq(prd_irq),
        .ch_irq(ch_irq), .trig_in(trig_in));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) event_in <= ~event_in & reset_n;

    // ****************************************
    // Bus tasks and comparisons
    // ****************************************
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd_reg(a, v);
        n_checks++;
        if (v !== exp) begin
            num_errors++;
            $display("MISMATCH %0t reg %0h read %h expected %h", $time, a, v, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            num_errors++;
            $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 8000);
        num_errors++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        num_errors = 0;
        n_checks = 0;
        seed = 55505;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 9; i++) chk_rd(4'(i), (i == 6) ? 16'hffff : 16'h0000);
        wr_reg(trig_timer_pkg::OFS_RUN_CTL, 16'hffff);
        chk_rd(trig_timer_pkg::OFS_RUN_CTL, 16'h0087);
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'hffbf);
        chk_rd(trig_timer_pkg::OFS_MODE_CTL, 16'h0027);
        chk_rd(trig_timer_pkg::OFS_COUNT, 16'hffff);
        wr_reg(trig_timer_pkg::OFS_RUN_CTL, 16'h0000);
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'h0000);
        // Triggered PWM: ch2 at zero, ch3 at period plus one
        p = 4 + ($unsigned($random(seed)) % 16);
        ck = 1 + ($unsigned($random(seed)) % (p - 2));
        wr_reg(trig_timer_pkg::OFS_PERIOD, 16'(p));
        wr_reg(trig_timer_pkg::OFS_CH2, 16'h0000);
        wr_reg(trig_timer_pkg::OFS_CH3, 16'(p + 1));
        wr_reg(trig_timer_pkg::OFS_CH1, 16'(ck));
        chk_rd(trig_timer_pkg::OFS_STATUS, 16'h0002);
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'(trig_timer_pkg::MODE_TRIG_PWM));
        wr_reg(trig_timer_pkg::OFS_RUN_CTL, 16'h0080);
        far_u.fire(t);
        chk_n(far_u.rise[0], t + 1);
        far_u.clear();
        repeat (3 * (p + 1)) @(posedge clk);
        chk_n(far_u.hi[0], 3 * ck);
        chk_n(far_u.hi[1], 0);
        chk_n(far_u.hi[2], 3 * (p + 1));
        chk_n(far_u.n_prd, 3);
        chk_n(far_u.n_ch[0], 3);
        chk_n(far_u.n_ch[1], 3);
        chk_n(far_u.n_ch[2], 0);
        chk_rd(trig_timer_pkg::OFS_STATUS, 16'h0001);
        w2 = 1 + ($unsigned($random(seed)) % p);
        wr_reg(trig_timer_pkg::OFS_CH2, 16'(w2));
        repeat (p + 3) @(posedge clk);
        far_u.clear();
        repeat (p + 1) @(posedge clk);
        chk_n(far_u.hi[1], 0);
        wr_reg(trig_timer_pkg::OFS_CH1, 16'(ck));
        repeat (p + 3) @(posedge clk);
        far_u.clear();
        repeat (p + 1) @(posedge clk);
        chk_n(far_u.hi[1], w2);
        // Period only: longer period, channel 1 rewritten unchanged
        wr_reg(trig_timer_pkg::OFS_PERIOD, 16'(p + 2));
        wr_reg(trig_timer_pkg::OFS_CH1, 16'(ck));
        repeat (p + 3) @(posedge clk);
        far_u.clear();
        repeat (2 * (p + 3)) @(posedge clk);
        chk_n(far_u.n_prd, 2);
        chk_n(far_u.hi[0], 2 * ck);
        // Retrigger during the inactive phase
        @(negedge clk);
        for (int i = 0; i < 40 && po[0] !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 40 && po[0] !== 1'b0; i++) @(negedge clk);
        far_u.fire(t);
        chk_n(far_u.rise[0], t + 1);
        // One-shot with soft trigger and an ignored external trigger
        wr_reg(trig_timer_pkg::OFS_RUN_CTL, 16'h0000);
        chk_rd(trig_timer_pkg::OFS_COUNT, 16'hffff);
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'(trig_timer_pkg::MODE_ONE_SHOT));
        wr_reg(trig_timer_pkg::OFS_PERIOD, 16'(p));
        for (int k = 0; k < 3; k++) begin
            c[k] = 1 + ($unsigned($random(seed)) % p);
            wr_reg(trig_timer_pkg::OFS_CH1 + 4'(k), 16'(c[k]));
        end
        wr_reg(trig_timer_pkg::OFS_RUN_CTL, 16'h0080);
        repeat (3) @(posedge clk);
        chk_rd(trig_timer_pkg::OFS_COUNT, 16'hffff);
        far_u.clear();
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'h0043);
        far_u.fire(t);
        repeat (p + 4) @(posedge clk);
        for (int k = 0; k < 3; k++) begin
            chk_n(far_u.rise[k] - far_u.aux_rise, c[k]);
            chk_n(far_u.fall[k] - far_u.rise[k], p - c[k] + 1);
            chk_n(far_u.n_ch[k], 1);
        end
        chk_n(far_u.n_aux, 1);
        chk_n(far_u.aux_fall - far_u.aux_rise, p + 1);
        chk_n(far_u.n_prd, 1);
        chk_rd(trig_timer_pkg::OFS_COUNT, 16'hffff);
        // One-shot again, counting event edges that come every other clock
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'h0023);
        wr_reg(trig_timer_pkg::OFS_MODE_CTL, 16'h0063);
        repeat (2 * p + 6) @(posedge clk);
        chk_n(far_u.fall[0] - far_u.rise[0], 2 * (p - c[0] + 1));
        chk_n(far_u.n_prd, 2);
        results();
    end
endmodule
`default_nettype wire
